// ---- core/motor_driver_config_regs.sv ----
// configuration registers and phase decode of a three-phase driver
// assumes a host register port on i_mclk: address, write strobe, data
// assumes phase inputs are asynchronous pins
`timescale 1ns/100ps
`include "motor_cfg_map.svh"

// Notes on behaviour
// - bit 3 enables asynchronous rectification
// - bit 2 enables synchronous rectification, reset off
// - bits 1-0 select sense amplifier gain
// - reserved bits read zero, read-only
// - buck bit 4 disables power sequencing
// - buck bit 3 selects 600/150 mA limit
// - buck bits 2-1 select output voltage
// - buck bit 0 turns regulator off
// - delay bit 4 enables compensation, reset off
// - delay bits 3-0 select compensation target
// - buck register at 0x8, resets zero
// - delay register at 0xc, resets zero
// - enabled phase follows its input level
// - equal enabled inputs give brake or high
// - disabled phase output is high impedance
// - lock code blocks writes, unlock code restores
module motor_driver_config_regs (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_phase_a_drive_level,
  input wire logic i_phase_a_output_allow,
  input wire logic i_phase_b_drive_level,
  input wire logic i_phase_b_output_allow,
  input wire logic i_phase_c_drive_level,
  input wire logic i_phase_c_output_allow,
  output logic [2:0] o_phase_terminal,
  output logic [2:0] o_phase_terminal_en_n,
  output logic o_async_rectify_on,
  output logic o_sync_rectify_on,
  output logic [1:0] o_sense_amp_gain_sel,
  output logic o_regulator_sequencing_off,
  output logic o_regulator_current_limit_sel,
  output logic [1:0] o_regulator_voltage_sel,
  output logic o_regulator_off,
  output logic o_delay_comp_on,
  output logic [3:0] o_delay_comp_target,
  output logic o_regs_locked
);
  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [7:0] rectification_sense_config; // rect/sense register
  logic [7:0] buck_regulator_config; // buck register
  logic [7:0] delay_compensation_config; // delay register
  logic [7:0] lock_ctrl; // lock field register
  logic wr_open; // writes accepted outside the lock field

  // the lock field itself always accepts writes
  assign wr_open = (lock_ctrl[2:0] != `LOCK_CODE);

  // lock field register; reset value carries no lock
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock_ctrl <= `LK_RESET;
    end else if (i_reg_wr && i_reg_addr == `ADDR_LOCK_CTRL) begin
      lock_ctrl <= i_reg_wdata & `LK_WMASK;
    end
  end

  // rectification and sense gain register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rectification_sense_config <= `RS_RESET;
    end else if (i_reg_wr && wr_open &&
                 i_reg_addr == `ADDR_RECT_SENSE) begin
      rectification_sense_config <= i_reg_wdata & `RS_WMASK;
    end
  end

  // buck regulator register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      buck_regulator_config <= `BK_RESET;
    end else if (i_reg_wr && wr_open &&
                 i_reg_addr == `ADDR_BUCK_CFG) begin
      buck_regulator_config <= i_reg_wdata & `BK_WMASK;
    end
  end

  // delay compensation register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      delay_compensation_config <= `DC_RESET;
    end else if (i_reg_wr && wr_open &&
                 i_reg_addr == `ADDR_DELAY_CFG) begin
      delay_compensation_config <= i_reg_wdata & `DC_WMASK;
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      case (i_reg_addr)
        `ADDR_LOCK_CTRL: o_reg_rdata <= lock_ctrl;
        `ADDR_RECT_SENSE: o_reg_rdata <= rectification_sense_config;
        `ADDR_BUCK_CFG: o_reg_rdata <= buck_regulator_config;
        `ADDR_DELAY_CFG: o_reg_rdata <= delay_compensation_config;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ***************************************************************
  // control outputs to the analog blocks
  // ***************************************************************
  assign o_async_rectify_on =
    rectification_sense_config[`RS_ASYNC_BIT];
  assign o_sync_rectify_on =
    rectification_sense_config[`RS_SYNC_BIT];
  assign o_sense_amp_gain_sel = rectification_sense_config[1:0];
  assign o_regulator_sequencing_off =
    buck_regulator_config[`BK_SEQ_OFF_BIT];
  assign o_regulator_current_limit_sel =
    buck_regulator_config[`BK_CL_BIT];
  assign o_regulator_voltage_sel =
    buck_regulator_config[`BK_VSEL_HI:`BK_VSEL_LO];
  assign o_regulator_off = buck_regulator_config[`BK_OFF_BIT];
  assign o_delay_comp_on = delay_compensation_config[`DC_ON_BIT];
  assign o_delay_comp_target = delay_compensation_config[3:0];
  assign o_regs_locked = ~wr_open;

  // ***************************************************************
  // phase input synchronisers and decode
  // ***************************************************************
  logic [2:0] lvl_meta; // first stage, read only by second
  logic [2:0] lvl_sync;
  logic [2:0] allow_meta; // first stage, read only by second
  logic [2:0] allow_sync;

  // two-flop synchronisers for all pin inputs
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvl_meta <= 3'h0;
      lvl_sync <= 3'h0;
      allow_meta <= 3'h0;
      allow_sync <= 3'h0;
    end else begin
      lvl_meta <= {i_phase_c_drive_level, i_phase_b_drive_level,
                   i_phase_a_drive_level};
      lvl_sync <= lvl_meta;
      allow_meta <= {i_phase_c_output_allow, i_phase_b_output_allow,
                     i_phase_a_output_allow};
      allow_sync <= allow_meta;
    end
  end

  // one decoder per half-bridge
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
      phase_decode u_dec (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_level(lvl_sync[ph]),
        .i_allow(allow_sync[ph]),
        .o_drive(o_phase_terminal[ph]),
        .o_drive_en_n(o_phase_terminal_en_n[ph]),
        .o_state()
      );
    end
  endgenerate
endmodule : motor_driver_config_regs

// ---- core/motor_cfg_map.svh ----
// register offsets, field positions and reset values of the configuration slice
// assumes an 8-bit register port with 4-bit addresses driven by the host
`ifndef MOTOR_CFG_MAP_SVH
`define MOTOR_CFG_MAP_SVH

// ***************************************************************
// register addresses
// ***************************************************************
`define ADDR_LOCK_CTRL 4'h3
`define ADDR_RECT_SENSE 4'h7
`define ADDR_BUCK_CFG 4'h8
`define ADDR_DELAY_CFG 4'hc

// ***************************************************************
// field positions
// ***************************************************************
`define RS_ASYNC_BIT 3
`define RS_SYNC_BIT 2
`define BK_SEQ_OFF_BIT 4
`define BK_CL_BIT 3
`define BK_VSEL_HI 2
`define BK_VSEL_LO 1
`define BK_OFF_BIT 0
`define DC_ON_BIT 4

// ***************************************************************
// writable masks and reset values
// ***************************************************************
`define RS_WMASK 8'h0f
`define BK_WMASK 8'h1f
`define DC_WMASK 8'h1f
`define LK_WMASK 8'h07
`define RS_RESET 8'h00
`define BK_RESET 8'h00
`define DC_RESET 8'h00
`define LK_RESET 8'h01
`define LOCK_CODE 3'h6
`define UNLOCK_CODE 3'h3

`endif

// ---- core/motor_cfg_pkg.sv ----
// types shared by the configuration slice
// assumes the map header supplies all numbers
package motor_cfg_pkg;
  // drive state of one half-bridge
  typedef enum logic [2:0] {
    PH_COAST = 3'b001,
    PH_LOW = 3'b010,
    PH_HIGH = 3'b100
  } phase_state_e;
endpackage : motor_cfg_pkg

// ---- core/phase_decode.sv ----
// decodes one half-bridge from its level and allow inputs
// assumes inputs are already synchronised to i_mclk
`timescale 1ns/100ps
module phase_decode (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_level,
  input wire logic i_allow,
  output logic o_drive,
  output logic o_drive_en_n,
  output motor_cfg_pkg::phase_state_e o_state
);
  // ***************************************************************
  // registered half-bridge state
  // ***************************************************************
  // registered so the pin never glitches between coast and drive
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_state <= motor_cfg_pkg::PH_COAST;
    end else if (!i_allow) begin
      o_state <= motor_cfg_pkg::PH_COAST;
    end else if (i_level) begin
      o_state <= motor_cfg_pkg::PH_HIGH;
    end else begin
      o_state <= motor_cfg_pkg::PH_LOW;
    end
  end

  // pin level and enable (enable low while driving)
  always_comb begin
    case (o_state)
      motor_cfg_pkg::PH_HIGH: begin
        o_drive = 1'b1;
        o_drive_en_n = 1'b0;
      end
      motor_cfg_pkg::PH_LOW: begin
        o_drive = 1'b0;
        o_drive_en_n = 1'b0;
      end
      default: begin
        o_drive = 1'b0;
        o_drive_en_n = 1'b1;
      end
    endcase
  end
endmodule : phase_decode

// ---- test/motor_cfg_properties.sv ----
// timing checks on the configuration slice ports
// assumes bind to motor_driver_config_regs, one clock domain
`timescale 1ns/100ps
module motor_cfg_properties (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_phase_a_drive_level,
  input wire logic i_phase_a_output_allow,
  input wire logic [2:0] o_phase_terminal,
  input wire logic [2:0] o_phase_terminal_en_n,
  input wire logic o_regulator_sequencing_off,
  input wire logic o_regulator_current_limit_sel,
  input wire logic [1:0] o_regulator_voltage_sel,
  input wire logic o_regulator_off,
  input wire logic o_delay_comp_on,
  input wire logic [3:0] o_delay_comp_target,
  input wire logic o_regs_locked
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic [4:0] bk;
  logic [4:0] dc;
  // packed views of the two register images
  assign bk = {o_regulator_sequencing_off, o_regulator_current_limit_sel,
    o_regulator_voltage_sel, o_regulator_off};
  assign dc = {o_delay_comp_on, o_delay_comp_target};
  // three edges of a steady pin pass the two sync flops and the decode flop
  sequence s_a_held(lv);
    (i_phase_a_output_allow && i_phase_a_drive_level == lv) [*3];
  endsequence
  property p_buck_wr;
    i_reg_wr && i_reg_addr == 4'h8 && !o_regs_locked |=>
      bk == $past(i_reg_wdata[4:0]);
  endproperty
  a_buck_wr:
    assert property (p_buck_wr) else $error("buck write not applied");
  property p_dly_wr;
    i_reg_wr && i_reg_addr == 4'hc && !o_regs_locked |=>
      dc == $past(i_reg_wdata[4:0]);
  endproperty
  a_dly_wr:
    assert property (p_dly_wr) else $error("delay write not applied");
  property p_lock_set;
    i_reg_wr && i_reg_addr == 4'h3 && i_reg_wdata[2:0] == 3'h6 |=>
      o_regs_locked;
  endproperty
  a_lock_set:
    assert property (p_lock_set) else $error("lock code not taken");
  property p_lock_hold;
    o_regs_locked |=> $stable({bk, dc});
  endproperty
  a_lock_hold:
    assert property (p_lock_hold) else $error("locked register changed");
  property p_unlock;
    i_reg_wr && i_reg_addr == 4'h3 && i_reg_wdata[2:0] == 3'h3 |=>
      !o_regs_locked;
  endproperty
  a_unlock:
    assert property (p_unlock) else $error("unlock code not taken");
  property p_rd_buck;
    $past(i_reg_addr) == 4'h8 |-> o_reg_rdata == {3'h0, $past(bk)};
  endproperty
  a_rd_buck:
    assert property (p_rd_buck) else $error("buck readback wrong");
  property p_ph_hi;
    s_a_held(1'b1) |=> o_phase_terminal[0] && !o_phase_terminal_en_n[0];
  endproperty
  a_ph_hi:
    assert property (p_ph_hi) else $error("phase not driven high");
  property p_ph_lo;
    s_a_held(1'b0) |=> !o_phase_terminal[0] && !o_phase_terminal_en_n[0];
  endproperty
  a_ph_lo:
    assert property (p_ph_lo) else $error("phase not driven low");
  property p_coast;
    !i_phase_a_output_allow [*3] |=> o_phase_terminal_en_n[0];
  endproperty
  a_coast:
    assert property (p_coast) else $error("phase not released");
endmodule : motor_cfg_properties
bind motor_driver_config_regs motor_cfg_properties motor_cfg_properties_i (.*);

// ---- test/host_port_model.sv ----
// host controller side of the register port
// assumes the bench calls its tasks; pins move on falling edges only
`timescale 1ns/100ps
module host_port_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_reg_rdata,
  output logic [3:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 4'h0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // one-cycle strobe; data inverted after release so stale data never fits
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_wr = 1'b1;
    o_reg_wdata = d;
    @(negedge i_mclk);
    o_reg_wr = 1'b0;
    o_reg_wdata = ~d;
  endtask : write_reg
  // read back to confirm what the device accepted
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    @(negedge i_mclk);
    d = i_reg_rdata;
  endtask : read_reg
endmodule : host_port_model

// ---- test/tb_top.sv ----
// self-checking bench for the configuration slice
// assumes the host model drives the register port
`timescale 1ns/100ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] lvl = 3'h0;
  logic [2:0] alw = 3'h0;
  logic [2:0] term;
  logic [2:0] en_n;
  logic [4:0] bk;
  logic [4:0] dc;
  logic [3:0] rs;
  logic locked;
  int err_total = 0;
  int checks_done = 0;
  always #2.5 i_mclk = ~i_mclk;
  host_port_model host_port_model_i (.i_mclk(i_mclk), .i_reg_rdata(rdata),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata));
  motor_driver_config_regs motor_driver_config_regs_i (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_phase_a_drive_level(lvl[0]), .i_phase_a_output_allow(alw[0]),
    .i_phase_b_drive_level(lvl[1]), .i_phase_b_output_allow(alw[1]),
    .i_phase_c_drive_level(lvl[2]), .i_phase_c_output_allow(alw[2]),
    .o_phase_terminal(term), .o_phase_terminal_en_n(en_n),
    .o_async_rectify_on(rs[3]), .o_sync_rectify_on(rs[2]),
    .o_sense_amp_gain_sel(rs[1:0]), .o_regulator_sequencing_off(bk[4]),
    .o_regulator_current_limit_sel(bk[3]),
    .o_regulator_voltage_sel(bk[2:1]), .o_regulator_off(bk[0]),
    .o_delay_comp_on(dc[4]), .o_delay_comp_target(dc[3:0]),
    .o_regs_locked(locked));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rb(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_port_model_i.read_reg(a, d);
    chk(d, exp);
  endtask : rb
  task automatic conclude;
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic t_reset_vals;
    rb(4'h8, 8'h00);
    rb(4'hc, 8'h00);
    rb(4'h7, 8'h00);
    rb(4'h3, 8'h01);
    chk({5'h0, en_n}, 8'h07);
  endtask : t_reset_vals
  // reserved bits are written as ones by 8'hff and must read back as zero
  task automatic t_buck;
    logic [7:0] v [4];
    v = '{8'hff, 8'h0a, 8'h15, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host_port_model_i.write_reg(4'h8, v[i]);
      rb(4'h8, v[i] & 8'h1f);
      chk({3'h0, bk}, v[i] & 8'h1f);
    end
  endtask : t_buck
  task automatic t_delay;
    for (int k = 0; k < 16; k++) begin
      host_port_model_i.write_reg(4'hc, {3'h7, k[0], k[3:0]});
      rb(4'hc, {3'h0, k[0], k[3:0]});
      chk({3'h0, dc}, {3'h0, k[0], k[3:0]});
    end
  endtask : t_delay
  task automatic t_rect;
    for (int g = 0; g < 4; g++) begin
      host_port_model_i.write_reg(4'h7, {4'hf, g[1:0], g[1:0]});
      rb(4'h7, {4'h0, g[1:0], g[1:0]});
      chk({4'h0, rs}, {4'h0, g[1:0], g[1:0]});
    end
  endtask : t_rect
  // locked writes and unmapped writes must leave no trace
  task automatic t_lock;
    host_port_model_i.write_reg(4'h3, 8'h06);
    rb(4'h3, 8'h06);
    chk({7'h0, locked}, 8'h01);
    host_port_model_i.write_reg(4'h8, 8'h1f);
    rb(4'h8, 8'h00);
    host_port_model_i.write_reg(4'h5, 8'hff);
    rb(4'h5, 8'h00);
    host_port_model_i.write_reg(4'h3, 8'hfb);
    rb(4'h3, 8'h03);
    chk({7'h0, locked}, 8'h00);
    host_port_model_i.write_reg(4'h8, 8'h0a);
    rb(4'h8, 8'h0a);
  endtask : t_lock
  // the pins pass three flops, so look on the falling edge after the third rising edge past each change
  task automatic t_phase;
    for (int p = 0; p < 9; p++) begin
      @(negedge i_mclk);
      lvl = p[2:0];
      alw = (p == 8) ? 3'h0 : 3'h7;
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({5'h0, en_n}, (p == 8) ? 8'h07 : 8'h00);
      if (p < 8) chk({5'h0, term}, p[7:0]);
    end
  endtask : t_phase
  initial begin
    #100000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset_vals();
    t_buck();
    t_delay();
    t_rect();
    t_lock();
    t_phase();
    conclude();
  end
endmodule : tb_top
